// [core/papi_host.sv]
module papi_host
    import papi_pkg::*;
#(
    parameter int DPD_PULSE_CYCLES = papi_pkg::DPD_PULSE_CYC
) (
    // Clock and reset
    input  wire logic                        clk_sys,
    input  wire logic                        rst_n,
    // Request
    input  wire logic                        req_valid,
    input  wire papi_pkg::papi_req_type      req,
    output      logic                        req_ready,
    // Response
    output      logic                        rsp_valid,
    output      papi_pkg::papi_rsp_type      rsp,
    // Power control and status
    input  wire logic                        wake_req,
    input  wire logic                        lost_clear,
    output      logic                        data_lost,
    // Memory pins
    output      papi_pkg::papi_pins_type     mem_pins,
    input  wire logic [papi_pkg::DATA_W-1:0] mem_dq_in
);
    import papi_pkg::*;

    papi_host_state_type st_ff;
    papi_host_state_type nxt_st;

    logic             tmr_load;
    logic [TMR_W-1:0] tmr_val;
    logic             tmr_done;
    logic             lost_set;

    // ------------------------------------------------------------
    // Interval timer, preloaded with the power-up hold
    // ------------------------------------------------------------
    papi_timer #(
        .WIDTH     (TMR_W),
        .RESET_VAL (TMR_W'(POWERUP_CYC - 1))
    ) papi_timer_inst (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .load     (tmr_load),
        .load_val (tmr_val),
        .done     (tmr_done)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        nxt_st        = st_ff;
        tmr_load      = 1'b0;
        tmr_val       = '0;
        lost_set      = 1'b0;
        nxt_st.rsp_valid = 1'b0;
        // Data pins are asynchronous to clk_sys
        nxt_st.dq_meta = mem_dq_in;
        nxt_st.dq_sync = st_ff.dq_meta;

        unique case (st_ff.state)
            PAPI_ST_INIT: begin
                // Both selects held idle until the hold has run out
                if (tmr_done) begin
                    nxt_st.state = PAPI_ST_IDLE;
                end
            end

            PAPI_ST_IDLE: begin
                if (req_valid && st_ff.ready) begin
                    nxt_st.pins.addr = req.addr;
                    unique case (req.op)
                        PAPI_OP_READ, PAPI_OP_PAGE: begin
                            // Output strobe asserted only with write strobe high
                            nxt_st.pins.chip_select_n      = 1'b0;
                            nxt_st.pins.output_n           = 1'b0;
                            nxt_st.pins.write_n            = 1'b1;
                            nxt_st.pins.low_lane_enable_n  = ~req.byte_en[0];
                            nxt_st.pins.high_lane_enable_n = ~req.byte_en[1];
                            nxt_st.pins.dq_oe              = 1'b0;
                            nxt_st.words_left = (req.op == PAPI_OP_PAGE) ?
                                                3'h7 : 3'h0;
                            nxt_st.state = PAPI_ST_READ;
                            tmr_load     = 1'b1;
                            tmr_val      = TMR_W'(RD_WAIT_CYC - 1);
                        end
                        PAPI_OP_WRITE: begin
                            // Select, lanes and strobe fall on one edge
                            nxt_st.pins.chip_select_n      = 1'b0;
                            nxt_st.pins.write_n            = 1'b0;
                            nxt_st.pins.output_n           = 1'b1;
                            nxt_st.pins.low_lane_enable_n  = ~req.byte_en[0];
                            nxt_st.pins.high_lane_enable_n = ~req.byte_en[1];
                            nxt_st.pins.dq_out = req.wdata;
                            // Memory released the bus during the idle gap
                            nxt_st.pins.dq_oe  = 1'b1;
                            nxt_st.state = PAPI_ST_WRITE;
                            tmr_load     = 1'b1;
                            // Covers select, lane and address setup to write end
                            tmr_val      = TMR_W'(WR_PULSE_CYC - 1);
                        end
                        PAPI_OP_SLEEP: begin
                            nxt_st.pins.chip_select_n   = 1'b1;
                            nxt_st.pins.power_select_hi = 1'b0;
                            nxt_st.state = PAPI_ST_DPD;
                            lost_set     = 1'b1;
                            tmr_load     = 1'b1;
                            tmr_val      = TMR_W'(DPD_PULSE_CYCLES - 1);
                        end
                        default: begin
                            nxt_st.state = PAPI_ST_IDLE;
                        end
                    endcase
                end
            end

            PAPI_ST_READ: begin
                if (tmr_done) begin
                    nxt_st.rsp_valid = 1'b1;
                    // Deselected lane is undriven, so report it as zero
                    nxt_st.rsp.rdata = {st_ff.pins.high_lane_enable_n ? 8'h00
                                                                      : st_ff.dq_sync[15:8],
                                        st_ff.pins.low_lane_enable_n ? 8'h00
                                                                     : st_ff.dq_sync[7:0]};
                    if (st_ff.words_left == '0) begin
                        nxt_st.rsp.last = 1'b1;
                        nxt_st.pins     = PINS_IDLE;
                        nxt_st.pins.addr = st_ff.pins.addr;
                        nxt_st.state    = PAPI_ST_GAP;
                        tmr_load        = 1'b1;
                        tmr_val         = TMR_W'(GAP_CYC - 1);
                    end else begin
                        // Only the page bits move inside a page
                        nxt_st.rsp.last  = 1'b0;
                        nxt_st.words_left = st_ff.words_left - 3'h1;
                        nxt_st.pins.addr[PAGE_BITS-1:0] =
                            st_ff.pins.addr[PAGE_BITS-1:0] + 3'h1;
                        tmr_load = 1'b1;
                        // Spacing well above the page access time
                        tmr_val  = TMR_W'(PG_WAIT_CYC - 1);
                    end
                end
            end

            PAPI_ST_WRITE: begin
                if (tmr_done) begin
                    // Select and lanes rise with the write strobe
                    nxt_st.pins      = PINS_IDLE;
                    nxt_st.pins.addr = st_ff.pins.addr;
                    nxt_st.state     = PAPI_ST_GAP;
                    tmr_load         = 1'b1;
                    tmr_val          = TMR_W'(GAP_CYC - 1);
                end
            end

            PAPI_ST_GAP: begin
                // One idle cycle exceeds both high-pulse minimums
                // Every access ends here, so no short cycles can pile up
                if (tmr_done) begin
                    nxt_st.state = PAPI_ST_IDLE;
                end
            end

            PAPI_ST_DPD: begin
                if (tmr_done && wake_req) begin
                    // Chip select stays high through recovery
                    nxt_st.pins.power_select_hi = 1'b1;
                    nxt_st.state = PAPI_ST_WAKE;
                    tmr_load     = 1'b1;
                    tmr_val      = TMR_W'(RECOVER_CYC - 1);
                end
            end

            PAPI_ST_WAKE: begin
                if (tmr_done) begin
                    nxt_st.state = PAPI_ST_IDLE;
                end
            end

            default: begin
                nxt_st.pins  = PINS_IDLE;
                nxt_st.state = PAPI_ST_GAP;
            end
        endcase

        nxt_st.ready = (nxt_st.state == PAPI_ST_IDLE);

        // A new power-down wins over a clear in the same cycle
        if (lost_clear) begin
            nxt_st.data_lost = 1'b0;
        end
        if (lost_set) begin
            nxt_st.data_lost = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff <= HOST_RESET;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from the state register
    // ------------------------------------------------------------
    assign req_ready = st_ff.ready;
    assign rsp_valid = st_ff.rsp_valid;
    assign rsp       = st_ff.rsp;
    assign data_lost = st_ff.data_lost;
    assign mem_pins  = st_ff.pins;

endmodule : papi_host

// [core/papi_pkg.sv]
package papi_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int ADDR_W      = 22;
    localparam int DATA_W      = 16;
    localparam int TMR_W       = 20;
    localparam int PAGE_BITS   = 3;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Timing, in ns, us or ms as printed, and cycles at 10 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS      = 100;
    localparam int READ_ACCESS_NS     = 70;
    localparam int PAGE_ACCESS_NS     = 30;
    localparam int SELECT_TO_WR_NS    = 70;
    localparam int LANE_TO_WR_NS      = 60;
    localparam int ADDR_TO_WR_NS      = 60;
    localparam int SELECT_HIGH_NS     = 10;
    localparam int WRITE_HIGH_NS      = 6;
    localparam int POWERUP_HOLD_US    = 30;
    localparam int DPD_PULSE_MS       = 10;
    localparam int DPD_RECOVER_US     = 300;

    localparam int READ_ACC_CYC  = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_ACC_CYC  = (PAGE_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC  = (SELECT_TO_WR_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int GAP_CYC       = (SELECT_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC   = (POWERUP_HOLD_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int DPD_PULSE_CYC = (DPD_PULSE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RECOVER_CYC   = (DPD_RECOVER_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Data must also cross the two input flops before it is sampled
    localparam int RD_WAIT_CYC   = READ_ACC_CYC + SYNC_STAGES;
    localparam int PG_WAIT_CYC   = PAGE_ACC_CYC + SYNC_STAGES;

    // ------------------------------------------------------------
    // Commands and states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PAPI_OP_READ  = 2'h0,
        PAPI_OP_WRITE = 2'h1,
        PAPI_OP_PAGE  = 2'h2,
        PAPI_OP_SLEEP = 2'h3
    } papi_op_type;

    typedef enum logic [2:0] {
        PAPI_ST_INIT  = 3'h0,
        PAPI_ST_IDLE  = 3'h1,
        PAPI_ST_READ  = 3'h2,
        PAPI_ST_WRITE = 3'h3,
        PAPI_ST_GAP   = 3'h4,
        PAPI_ST_DPD   = 3'h5,
        PAPI_ST_WAKE  = 3'h6
    } papi_state_type;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        papi_op_type         op;
        logic [ADDR_W-1:0]   addr;
        logic [DATA_W-1:0]   wdata;
        logic [1:0]          byte_en;
    } papi_req_type;

    typedef struct packed {
        logic [DATA_W-1:0]   rdata;
        logic                last;
    } papi_rsp_type;

    typedef struct packed {
        logic [ADDR_W-1:0]   addr;
        logic                chip_select_n;
        logic                power_select_hi;
        logic                write_n;
        logic                output_n;
        logic                low_lane_enable_n;
        logic                high_lane_enable_n;
        logic [DATA_W-1:0]   dq_out;
        logic                dq_oe;
    } papi_pins_type;

    typedef struct packed {
        papi_state_type      state;
        papi_pins_type       pins;
        logic [PAGE_BITS-1:0] words_left;
        logic                ready;
        logic                rsp_valid;
        papi_rsp_type        rsp;
        logic                data_lost;
        logic [DATA_W-1:0]   dq_meta;
        logic [DATA_W-1:0]   dq_sync;
    } papi_host_state_type;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam papi_pins_type PINS_IDLE = '{
        addr:               '0,
        chip_select_n:      1'h1,
        power_select_hi:    1'h1,
        write_n:            1'h1,
        output_n:           1'h1,
        low_lane_enable_n:  1'h1,
        high_lane_enable_n: 1'h1,
        dq_out:             '0,
        dq_oe:              1'h0
    };

    localparam papi_host_state_type HOST_RESET = '{
        state:      PAPI_ST_INIT,
        pins:       PINS_IDLE,
        words_left: '0,
        ready:      1'h0,
        rsp_valid:  1'h0,
        rsp:        '0,
        data_lost:  1'h0,
        dq_meta:    '0,
        dq_sync:    '0
    };

endpackage : papi_pkg

// [core/papi_timer.sv]
module papi_timer #(
    parameter int               WIDTH     = 20,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    // Load
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] load_val,
    // Status
    output      logic             done
);
    import papi_pkg::*;

    typedef struct packed {
        logic [WIDTH-1:0] cnt;
    } papi_tmr_state_type;

    papi_tmr_state_type tmr_ff;
    papi_tmr_state_type nxt_tmr;

    // ------------------------------------------------------------
    // Countdown, saturating at zero
    // ------------------------------------------------------------
    always_comb begin
        nxt_tmr = tmr_ff;
        if (load) begin
            nxt_tmr.cnt = load_val;
        end else if (tmr_ff.cnt != '0) begin
            nxt_tmr.cnt = tmr_ff.cnt - 1'b1;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            tmr_ff.cnt <= RESET_VAL;
        end else begin
            tmr_ff <= nxt_tmr;
        end
    end

    assign done = (tmr_ff.cnt == '0);

endmodule : papi_timer

// [test/papi_host_asserts.sv]
module papi_host_asserts
    import papi_pkg::*;
#(
    parameter int DPD_PULSE_CYCLES = 8
) (
    // Clock and reset
    input wire logic                    clk_sys,
    input wire logic                    rst_n,
    // Host side
    input wire logic                    req_valid,
    input wire logic                    req_ready,
    input wire logic                    rsp_valid,
    input wire logic                    data_lost,
    // Memory pins
    input wire papi_pkg::papi_pins_type mem_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] pu_cnt;
    logic [15:0] wk_cnt;
    logic [31:0] dpd_cnt;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    // The power-up and wake counters saturate, so long idle spans never wrap into a false window
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pu_cnt  <= '0;
            wk_cnt  <= 16'(RECOVER_CYC);
            dpd_cnt <= '0;
        end else begin
            pu_cnt  <= (pu_cnt < 16'(POWERUP_CYC)) ? pu_cnt + 16'h1 : pu_cnt;
            wk_cnt  <= !mem_pins.power_select_hi ? 16'h0 :
                       (wk_cnt < 16'(RECOVER_CYC)) ? wk_cnt + 16'h1 : wk_cnt;
            dpd_cnt <= mem_pins.power_select_hi ? 32'h0 : dpd_cnt + 32'h1;
        end
    end

    chk_powerup_idle: assert property (
        pu_cnt < 16'(POWERUP_CYC) |-> mem_pins.chip_select_n && mem_pins.power_select_hi)
        else $error("select left idle too early");
    chk_no_contend: assert property (
        mem_pins.dq_oe |-> mem_pins.output_n && !mem_pins.write_n && !mem_pins.chip_select_n)
        else $error("host drives data outside a write");
    chk_write_shape: assert property (
        $fell(mem_pins.write_n) |-> !mem_pins.chip_select_n && mem_pins.power_select_hi
        ##1 mem_pins.write_n && mem_pins.chip_select_n)
        else $error("write pulse shape wrong");
    chk_write_high: assert property (
        $rose(mem_pins.write_n) |-> mem_pins.write_n [*2])
        else $error("write strobe high too short");
    chk_select_gap: assert property (
        $rose(mem_pins.chip_select_n) |-> mem_pins.chip_select_n [*2])
        else $error("select high gap too short");
    chk_page_upper: assert property (
        !mem_pins.chip_select_n && !$past(mem_pins.chip_select_n) |-> $stable(mem_pins.addr[21:3]))
        else $error("upper address moved inside a cycle");
    chk_page_step: assert property (
        !mem_pins.chip_select_n && !$past(mem_pins.chip_select_n) && $changed(mem_pins.addr)
        |-> mem_pins.addr[2:0] == $past(mem_pins.addr[2:0]) + 3'h1 ##1 $stable(mem_pins.addr) [*2])
        else $error("page address step wrong");
    chk_read_answer: assert property (
        $fell(mem_pins.chip_select_n) && !mem_pins.output_n |-> ##3 rsp_valid)
        else $error("read word not answered in time");
    chk_sleep_pins: assert property (
        !mem_pins.power_select_hi |-> mem_pins.chip_select_n && data_lost)
        else $error("power-down pins or lost flag wrong");
    chk_sleep_pulse: assert property (
        mem_pins.power_select_hi && !$past(mem_pins.power_select_hi)
        |-> dpd_cnt >= 32'(DPD_PULSE_CYCLES))
        else $error("power-down pulse too short");
    chk_wake_wait: assert property (
        wk_cnt < 16'(RECOVER_CYC) |-> mem_pins.chip_select_n)
        else $error("access before wake recovery");
    chk_take_drop: assert property (req_valid && req_ready |=> !req_ready)
        else $error("ready stayed after a take");
endmodule : papi_host_asserts

bind papi_host papi_host_asserts #(
    .DPD_PULSE_CYCLES(DPD_PULSE_CYCLES)
) papi_host_asserts_inst (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .rsp_valid(rsp_valid),
    .data_lost(data_lost),
    .mem_pins (mem_pins)
);

// [test/papi_mem_model.sv]
module papi_mem_model
    import papi_pkg::*;
#(
    parameter int ACC_NS = 25
) (
    // Clock
    input  wire logic                        clk_sys,
    // Pins
    input  wire papi_pkg::papi_pins_type     mem_pins,
    output      logic [papi_pkg::DATA_W-1:0] dq
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [DATA_W-1:0] cells [int];
    logic [DATA_W-1:0] rword;
    logic [DATA_W-1:0] wword;
    logic [7:0]        noise = 8'h3c;
    logic              rd_on;

    initial dq = '0;
    // Output only when selected, powered, output strobe low and write strobe high
    assign rd_on = !mem_pins.chip_select_n && mem_pins.power_select_hi &&
                   mem_pins.write_n && !mem_pins.output_n;

    // Word follows the address after a page access delay under 30 ns
    always @(posedge clk_sys) begin
        #ACC_NS;
        noise = noise + 8'h5b;
        rword = cells.exists(int'(mem_pins.addr)) ? cells[int'(mem_pins.addr)] : {noise, ~noise};
        // A floating lane shows a moving pattern, never the last value
        dq[7:0]  = (rd_on && !mem_pins.low_lane_enable_n) ? rword[7:0] : noise;
        dq[15:8] = (rd_on && !mem_pins.high_lane_enable_n) ? rword[15:8] : ~noise;
    end

    always @(negedge clk_sys) begin
        if (!mem_pins.power_select_hi && mem_pins.chip_select_n) begin
            cells.delete();
        end
        if (!mem_pins.chip_select_n && mem_pins.power_select_hi && !mem_pins.write_n) begin
            wword = cells.exists(int'(mem_pins.addr)) ? cells[int'(mem_pins.addr)] : {2{noise}};
            if (!mem_pins.low_lane_enable_n) wword[7:0] = mem_pins.dq_out[7:0];
            if (!mem_pins.high_lane_enable_n) wword[15:8] = mem_pins.dq_out[15:8];
            cells[int'(mem_pins.addr)] = wword;
        end
    end
endmodule : papi_mem_model

// [test/tb_psram_async_page_interface.sv]
module tb_psram_async_page_interface;
    timeunit 1ns;
    timeprecision 1ns;
    import papi_pkg::*;
    typedef struct packed {logic [DATA_W-1:0] d; logic last;} papi_exp_type;
    logic              clk_sys, rst_n, req_valid, req_ready, rsp_valid, rdy_s;
    logic              wake_req, lost_clear, data_lost;
    papi_req_type      req;
    papi_rsp_type      rsp;
    papi_pins_type     mem_pins;
    logic [DATA_W-1:0] mem_dq_in;
    logic [DATA_W-1:0] shadow [int];
    papi_exp_type      expq [$];
    logic [31:0]       rnd;
    logic [21:0]       base;
    int                miscompares, n_tests, n;

    initial begin
        clk_sys = 1'h0;
        forever #50 clk_sys = ~clk_sys;
    end

    papi_host #(.DPD_PULSE_CYCLES(8)) papi_host_inst (
        .clk_sys(clk_sys), .rst_n(rst_n), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp(rsp), .wake_req(wake_req),
        .lost_clear(lost_clear), .data_lost(data_lost), .mem_pins(mem_pins),
        .mem_dq_in(mem_dq_in));
    papi_mem_model papi_mem_model_inst (.clk_sys(clk_sys), .mem_pins(mem_pins), .dq(mem_dq_in));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    function automatic logic [15:0] lanes(input logic [15:0] v, input logic [1:0] be);
        return {be[1] ? v[15:8] : 8'h0, be[0] ? v[7:0] : 8'h0};
    endfunction : lanes

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (exp !== got) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : check

    task automatic test_done;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // Held until taken; ready is read as it stood before the edge
    task automatic do_req(input papi_op_type op, input logic [21:0] a, input logic [15:0] d,
                          input logic [1:0] be);
        int k;
        k = 0;
        req_valid <= 1'h1;
        req       <= '{op: op, addr: a, wdata: d, byte_en: be};
        do begin
            @(posedge clk_sys);
            k++;
        end while (rdy_s !== 1'h1 && k < 5000);
        if (k >= 5000) miscompares++;
        req_valid <= 1'h0;
        @(posedge clk_sys);
    endtask : do_req

    task automatic wr(input logic [21:0] a, input logic [15:0] d, input logic [1:0] be);
        if (be[0]) shadow[int'(a)][7:0] = d[7:0];
        if (be[1]) shadow[int'(a)][15:8] = d[15:8];
        do_req(PAPI_OP_WRITE, a, d, be);
    endtask : wr

    task automatic rd(input papi_op_type op, input logic [21:0] a, input logic [1:0] be);
        logic [21:0] w;
        for (int i = 0; i < ((op == PAPI_OP_PAGE) ? 8 : 1); i++) begin
            w = {a[21:3], 3'(a[2:0] + i)};
            expq.push_back('{d: lanes(shadow[int'(w)], be), last: (op != PAPI_OP_PAGE || i == 7)});
        end
        do_req(op, a, 16'h0, be);
    endtask : rd

    // ----------------------------------------
    // Response watcher
    // ----------------------------------------
    always @(negedge clk_sys) begin
        papi_exp_type e;
        rdy_s = req_ready;
        if (rsp_valid === 1'h1) begin
            if (expq.size() == 0) begin
                check("spare response", 32'h0, 32'h1);
            end else begin
                e = expq.pop_front();
                check("read data", 32'(e.d), 32'(rsp.rdata));
                check("last flag", 32'(e.last), 32'(rsp.last));
            end
        end
    end

    initial begin
        #(20000 * 100);
        miscompares++;
        test_done();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rst_n = 1'h0; req_valid = 1'h0; req = '0; wake_req = 1'h0; lost_clear = 1'h0;
        miscompares = 0; n_tests = 0; rnd = 32'hca98; rdy_s = 1'h0;
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'h1;
        repeat (200) @(negedge clk_sys);
        check("ready in power-up", 32'h0, 32'(req_ready));
        check("select in power-up", 32'h1, 32'(mem_pins.chip_select_n));
        @(posedge clk_sys);
        rnd  = lfsr(rnd);
        base = {rnd[21:3], 3'h0};
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(base + 22'(i), rnd[15:0], 2'h3);
        end
        rnd = lfsr(rnd);
        wr(base + 22'h1, rnd[15:0], 2'h1);
        wr(base + 22'h2, ~rnd[15:0], 2'h2);
        wr(base + 22'h3, rnd[31:16], 2'h0);
        for (int b = 0; b < 4; b++) rd(PAPI_OP_READ, base + 22'(b), 2'(b));
        rd(PAPI_OP_PAGE, base + 22'h5, 2'h3);
        rd(PAPI_OP_PAGE, base + 22'h2, 2'h1);
        do_req(PAPI_OP_SLEEP, 22'h0, 16'h0, 2'h0);
        @(negedge clk_sys);
        check("lost after sleep", 32'h1, 32'(data_lost));
        check("power select low", 32'h0, 32'(mem_pins.power_select_hi));
        check("select high asleep", 32'h1, 32'(mem_pins.chip_select_n));
        shadow.delete();
        @(posedge clk_sys);
        wake_req <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (rdy_s !== 1'h1 && n < 5000);
        check("wake recovery", 32'h1, 32'(n > RECOVER_CYC));
        // A wake that never finishes must not slip through the count above
        check("ready after wake", 32'h1, 32'(rdy_s));
        wake_req   <= 1'h0;
        lost_clear <= 1'h1;
        @(posedge clk_sys);
        lost_clear <= 1'h0;
        @(negedge clk_sys);
        check("lost cleared", 32'h0, 32'(data_lost));
        @(posedge clk_sys);
        rnd = lfsr(rnd);
        wr(base, rnd[15:0], 2'h3);
        rd(PAPI_OP_READ, base, 2'h3);
        repeat (10) @(posedge clk_sys);
        check("responses drained", 32'h0, 32'(expq.size()));
        test_done();
    end
endmodule : tb_psram_async_page_interface
